// ### src/pes_top.sv
// power and environment sequencer: supply start, monitoring, grace shutdown
// assumes all status and switch pins are asynchronous; APB on sys_clk
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/10ps

module pes_top
    import pes_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // power pins
    input wire logic aux_power_ok,
    input wire logic front_switch_on,
    input wire logic remote_dc_enable_n,
    input wire logic [1:0] supply_present,
    input wire logic [1:0] supply_power_good,
    input wire logic [1:0] supply_overcurrent,
    output logic supply_enable_n,
    output logic supply_shutdown,
    // environment pins
    input wire logic [1:0] cpu_fan_ok,
    input wire logic cpu1_present,
    input wire logic [1:0] sys_fan_ok,
    input wire logic fan_kit_ok,
    input wire logic [7:0] temp_value,
    // remote control switches and outputs
    input wire logic remote_allow_switch,
    input wire logic modem_off_switch,
    input wire logic remote_powerdown_disable_switch,
    input wire logic restore_defaults_switch,
    output logic remote_control_enable,
    output logic modem_port_enable,
    output logic remote_use_defaults,
    // maintenance alert and operator panel
    output logic maint_alert_n,
    output logic panel_we,
    output logic [PANEL_POS_W-1:0] panel_pos,
    output logic [7:0] panel_char
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [SYNC_W-1:0] meta_reg, sync_reg;
    logic aux_s, sw_s, rdc_n_s, cpu1_s, kit_s;
    logic [1:0] pres_s, pg_s, oc_s, cfan_s, sfan_s;
    logic [3:0] swpack_s;
    logic [7:0] temp_s;

    // the temperature word feeds faults and alerts only at the once-a-second sample; the live status uses it every cycle
    always_ff @(posedge sys_clk) begin
        meta_reg <= {aux_power_ok, front_switch_on, remote_dc_enable_n, supply_present,
            supply_power_good, supply_overcurrent, cpu_fan_ok, cpu1_present, sys_fan_ok,
            fan_kit_ok, remote_allow_switch, modem_off_switch,
            remote_powerdown_disable_switch, restore_defaults_switch, temp_value};
        sync_reg <= meta_reg;
    end
    assign {aux_s, sw_s, rdc_n_s, pres_s, pg_s, oc_s, cfan_s, cpu1_s, sfan_s, kit_s,
        swpack_s, temp_s} = sync_reg;

    // ------------------------------------------------------------
    // one second tick
    // ------------------------------------------------------------
    logic [TICK_W-1:0] tick_cnt_reg, tick_cnt_next;
    logic tick;

    assign tick = (tick_cnt_reg == TICK_W'(TICK_CYCLES - 1));

    // free running time base for sampling and delays
    always_comb begin
        tick_cnt_next = tick ? '0 : tick_cnt_reg + TICK_W'(1);
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            tick_cnt_reg <= '0;
        end else begin
            tick_cnt_reg <= tick_cnt_next;
        end
    end

    // ------------------------------------------------------------
    // fault detection
    // ------------------------------------------------------------
    logic [7:0] thresh_reg, thresh_next;
    logic over_temp, cpu_fan_fail, sys_fan_fail, pg_fail, oc_fail, env_fault;
    logic remote_off, loop_open;
    logic [STAT_W-1:0] live_stat;

    assign over_temp = (temp_s > thresh_reg);
    assign cpu_fan_fail = ~&cfan_s;
    assign sys_fan_fail = ~&sfan_s | ~kit_s;
    assign pg_fail = |(pres_s & ~pg_s);
    assign oc_fail = |oc_s;
    // remote dc request only counts while remote control and power-down are allowed
    assign remote_off = rdc_n_s & swpack_s[3] & ~swpack_s[1];
    assign loop_open = ~sw_s | ~aux_s;
    // fans, temperature and power good are judged at the tick only
    assign env_fault = (tick & (over_temp | cpu_fan_fail | sys_fan_fail | pg_fail)) | oc_fail;
    assign live_stat = {kit_s, sfan_s, ~over_temp, cpu1_s, cfan_s, pg_s, pres_s};

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    pes_state_t state_reg, state_next;
    logic [SEC_W-1:0] sec_reg, sec_next;
    logic settled_reg, settled_next;

    always_comb begin
        state_next = state_reg;
        sec_next = sec_reg;
        settled_next = settled_reg;
        case (state_reg)
            PES_OFF: begin
                sec_next = '0;
                settled_next = 1'b0;
                if (!loop_open && !remote_off) begin
                    state_next = PES_ON;
                end
            end
            PES_ON: begin
                if (tick) begin
                    settled_next = 1'b1;
                end
                if (loop_open || remote_off) begin
                    state_next = PES_OFF;
                end else if (env_fault && (settled_reg || oc_fail)) begin
                    state_next = PES_GRACE;
                end
            end
            PES_GRACE: begin
                // supplies still run here, so any power-off request ends the delay
                if (loop_open || remote_off) begin
                    state_next = PES_OFF;
                end else if (tick) begin
                    if (sec_reg == SEC_W'(GRACE_TICKS - 1)) begin
                        state_next = PES_SHUT;
                    end
                    sec_next = sec_reg + SEC_W'(1);
                end
            end
            PES_SHUT: begin
                // held until the operator cycles the front switch
                if (!sw_s) begin
                    state_next = PES_OFF;
                end
            end
            default: begin
                state_next = PES_OFF;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            state_reg <= PES_OFF;
            sec_reg <= '0;
            settled_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            sec_reg <= sec_next;
            settled_reg <= settled_next;
        end
    end

    // ------------------------------------------------------------
    // status, alert and panel registers
    // ------------------------------------------------------------
    logic [STAT_W-1:0] stat_reg, stat_next;
    logic [3:0] alert_reg, alert_next, alert_set;
    logic [MEM_AW-1:0] maddr_reg, maddr_next;
    logic panel_we_next;
    logic [PANEL_POS_W-1:0] panel_pos_next;
    logic [7:0] panel_char_next;
    logic wr_acc, rd_setup, frozen;

    assign wr_acc = psel & penable & pready & pwrite;
    assign rd_setup = psel & ~penable;
    assign frozen = (state_reg == PES_GRACE) || (state_reg == PES_SHUT);
    assign alert_set = {oc_fail, tick & over_temp, tick & sys_fan_fail, tick & cpu_fan_fail};

    always_comb begin
        thresh_next = thresh_reg;
        maddr_next = maddr_reg;
        panel_we_next = 1'b0;
        panel_pos_next = panel_pos;
        panel_char_next = panel_char;
        stat_next = frozen ? stat_reg : live_stat;
        alert_next = alert_reg;
        if (wr_acc) begin
            case (paddr)
                OFS_THRESH: thresh_next = pwdata[7:0];
                OFS_ALERT: alert_next = alert_reg & ~pwdata[3:0];
                OFS_MEM_ADDR: maddr_next = pwdata[MEM_AW-1:0];
                OFS_PANEL: begin
                    panel_we_next = 1'b1;
                    panel_pos_next = pwdata[PANEL_POS_LSB +: PANEL_POS_W];
                    panel_char_next = pwdata[7:0];
                end
                default: begin
                end
            endcase
        end
        // a new event wins over a clear in the same cycle
        alert_next = alert_next | alert_set;
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            thresh_reg <= THRESH_RST;
            maddr_reg <= '0;
            panel_we <= 1'b0;
            panel_pos <= '0;
            panel_char <= '0;
            stat_reg <= '0;
            alert_reg <= ALERT_RST;
        end else begin
            thresh_reg <= thresh_next;
            maddr_reg <= maddr_next;
            panel_we <= panel_we_next;
            panel_pos <= panel_pos_next;
            panel_char <= panel_char_next;
            stat_reg <= stat_next;
            alert_reg <= alert_next;
        end
    end

    // ------------------------------------------------------------
    // info memory
    // ------------------------------------------------------------
    logic [MEM_DW-1:0] mem_rdata;

    // read address follows the next value so data is ready for the next setup
    pes_mem u_mem (
        .sys_clk(sys_clk),
        .wr_en(wr_acc && (paddr == OFS_MEM_DATA)),
        .wr_addr(maddr_reg),
        .wr_data(pwdata),
        .rd_addr(maddr_next),
        .rd_data(mem_rdata)
    );

    // ------------------------------------------------------------
    // apb answer and pin outputs
    // ------------------------------------------------------------
    logic [31:0] prdata_next;
    logic pready_next, pslverr_next, mapped;
    logic en_n_next, shut_next, alert_n_next;

    // zero wait slave: data and ready are prepared during setup
    always_comb begin
        prdata_next = '0;
        mapped = 1'b1;
        case (paddr)
            OFS_THRESH: prdata_next = {24'h000000, thresh_reg};
            OFS_STATUS: prdata_next = {21'h000000, stat_reg};
            OFS_LIVE: prdata_next = {21'h000000, live_stat};
            OFS_ALERT: prdata_next = {28'h0000000, alert_reg};
            OFS_STATE: begin
                prdata_next[0] = (state_reg == PES_ON);
                prdata_next[1] = (state_reg == PES_GRACE);
                prdata_next[2] = (state_reg == PES_SHUT);
                prdata_next[ST_SEC_LSB +: SEC_W] = sec_reg;
                prdata_next[ST_SW_LSB +: 4] = swpack_s;
            end
            OFS_MEM_ADDR: prdata_next = {27'h0000000, maddr_reg};
            OFS_MEM_DATA: prdata_next = mem_rdata;
            OFS_PANEL: prdata_next = '0;
            default: mapped = 1'b0;
        endcase
        if (!rd_setup || pwrite) begin
            prdata_next = '0;
        end
        pready_next = rd_setup;
        pslverr_next = rd_setup & ~mapped;
        en_n_next = ~((state_reg == PES_ON) || (state_reg == PES_GRACE));
        shut_next = (state_reg == PES_SHUT);
        alert_n_next = ~|alert_reg;
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            supply_enable_n <= 1'b1;
            supply_shutdown <= 1'b0;
            maint_alert_n <= 1'b1;
            remote_control_enable <= 1'b0;
            modem_port_enable <= 1'b0;
            remote_use_defaults <= 1'b0;
        end else begin
            prdata <= prdata_next;
            pready <= pready_next;
            pslverr <= pslverr_next;
            supply_enable_n <= en_n_next;
            supply_shutdown <= shut_next;
            maint_alert_n <= alert_n_next;
            remote_control_enable <= swpack_s[3];
            modem_port_enable <= ~swpack_s[2];
            remote_use_defaults <= swpack_s[0];
        end
    end
endmodule

// ### shared/pes_pkg.sv
// power and environment sequencer: shared constants and register map
// assumes a 20 MHz system clock and a 32-bit APB register port
package pes_pkg;
    // timing base
    localparam int CLK_HZ = 20_000_000;
    localparam int SAMPLE_PERIOD_MS = 1000;
    localparam int TICK_CYCLES_DEF = CLK_HZ / 1000 * SAMPLE_PERIOD_MS;
    localparam int GRACE_S = 30;
    localparam int GRACE_TICKS = GRACE_S * 1000 / SAMPLE_PERIOD_MS;
    localparam int TICK_W = 25;
    localparam int SEC_W = 5;

    // register byte offsets
    localparam logic [7:0] OFS_THRESH = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_LIVE = 8'h08;
    localparam logic [7:0] OFS_ALERT = 8'h0C;
    localparam logic [7:0] OFS_STATE = 8'h10;
    localparam logic [7:0] OFS_MEM_ADDR = 8'h14;
    localparam logic [7:0] OFS_MEM_DATA = 8'h18;
    localparam logic [7:0] OFS_PANEL = 8'h1C;

    // reset values
    localparam logic [7:0] THRESH_RST = 8'h37;
    localparam logic [3:0] ALERT_RST = 4'h0;

    // alert bit positions
    localparam int AL_CPU_FAN = 0;
    localparam int AL_SYS_FAN = 1;
    localparam int AL_TEMP = 2;
    localparam int AL_OVERCUR = 3;

    // status field width and positions of state register fields
    localparam int STAT_W = 11;
    localparam int ST_SEC_LSB = 8;
    localparam int ST_SW_LSB = 16;

    // info memory shape
    localparam int MEM_AW = 5;
    localparam int MEM_DW = 32;

    // panel write fields
    localparam int PANEL_POS_LSB = 8;
    localparam int PANEL_POS_W = 4;

    // width of the synchronised pin bundle
    localparam int SYNC_W = 27;

    typedef enum logic [1:0] {
        PES_OFF,
        PES_ON,
        PES_GRACE,
        PES_SHUT
    } pes_state_t;
endpackage

// ### src/pes_mem.sv
// power and environment sequencer: module info and scratch memory
// assumes one clock; read data is registered, write-first on a clash
`timescale 1ns/10ps
module pes_mem
    import pes_pkg::*;
(
    // clock, no reset
    input wire logic sys_clk,
    // write side
    input wire logic wr_en,
    input wire logic [MEM_AW-1:0] wr_addr,
    input wire logic [MEM_DW-1:0] wr_data,
    // read side
    input wire logic [MEM_AW-1:0] rd_addr,
    output logic [MEM_DW-1:0] rd_data
);
    logic [MEM_DW-1:0] mem_reg [0:(1<<MEM_AW)-1];
    logic [MEM_DW-1:0] rd_next;

    // write-first so a read of the word just written sees it
    always_comb begin
        if (wr_en && (wr_addr == rd_addr)) begin
            rd_next = wr_data;
        end else begin
            rd_next = mem_reg[rd_addr];
        end
    end

    // storage and read register
    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem_reg[wr_addr] <= wr_data;
        end
        rd_data <= rd_next;
    end
endmodule

// ### dv/pes_top_monitor.sv
// port checker for the power and environment sequencer
// assumes sys_clk with a synchronous active-low resetn
`timescale 1ns/10ps
module pes_top_monitor
    import pes_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // power
    input wire logic front_switch_on,
    input wire logic [1:0] supply_overcurrent,
    input wire logic supply_enable_n,
    input wire logic supply_shutdown,
    // remote switches
    input wire logic remote_allow_switch,
    input wire logic modem_off_switch,
    input wire logic restore_defaults_switch,
    input wire logic remote_control_enable,
    input wire logic modem_port_enable,
    input wire logic remote_use_defaults,
    // alert and panel
    input wire logic maint_alert_n,
    input wire logic panel_we,
    input wire logic [PANEL_POS_W-1:0] panel_pos,
    input wire logic [7:0] panel_char
);
    // ----
    // helpers
    // ----
    logic [2:0] up_reg;
    logic [2:0] up_next;
    logic panel_hit;
    logic [11:0] pc_word;
    // cycles since release; the sync stages have no reset, only the switch output registers hold reset values
    always_comb begin
        up_next = (up_reg == 3'h4) ? up_reg : up_reg + 3'h1;
        if (!resetn) begin
            up_next = 3'h0;
        end
    end
    always_ff @(posedge sys_clk) begin
        up_reg <= up_next;
    end
    assign panel_hit = psel && penable && pready && pwrite && (paddr == OFS_PANEL);
    assign pc_word = pwdata[11:0];

    // ----
    // assertions
    // ----
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    chk_reset_idle: assert property ($rose(resetn) |-> supply_enable_n && !supply_shutdown
        && maint_alert_n) else $error("outputs not idle after reset");
    chk_shut_from_on: assert property ($rose(supply_shutdown) |-> $past(supply_enable_n) == 1'b0)
        else $error("shutdown without prior grace");
    chk_apb_ready: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held too long");
    chk_allow_follow: assert property (up_reg == 3'h4 |->
        remote_control_enable == $past(remote_allow_switch, 3)) else $error("allow mismatch");
    chk_modem_follow: assert property (up_reg == 3'h4 |->
        modem_port_enable == !$past(modem_off_switch, 3)) else $error("modem mismatch");
    chk_defaults_follow: assert property (up_reg == 3'h4 |->
        remote_use_defaults == $past(restore_defaults_switch, 3)) else $error("defaults mismatch");
    chk_overcur_alert: assert property ((|supply_overcurrent)[*3] |-> ##[0:6] !maint_alert_n)
        else $error("overcurrent alert missing");
    chk_panel_write: assert property (panel_hit |=> panel_we && {panel_pos, panel_char} ==
        $past(pc_word)) else $error("panel write mismatch");
    chk_loop_open: assert property ((!front_switch_on)[*3] |-> ##[0:4] supply_enable_n)
        else $error("power kept with loop open");
    cover property (panel_hit);
    cover property ($rose(supply_shutdown));
    cover property (pslverr);
endmodule

bind pes_top pes_top_monitor mon (.sys_clk(sys_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .front_switch_on(front_switch_on),
    .supply_overcurrent(supply_overcurrent), .supply_enable_n(supply_enable_n),
    .supply_shutdown(supply_shutdown), .remote_allow_switch(remote_allow_switch),
    .modem_off_switch(modem_off_switch), .restore_defaults_switch(restore_defaults_switch),
    .remote_control_enable(remote_control_enable), .modem_port_enable(modem_port_enable),
    .remote_use_defaults(remote_use_defaults), .maint_alert_n(maint_alert_n),
    .panel_we(panel_we), .panel_pos(panel_pos), .panel_char(panel_char));

// ### dv/pes_supply_model.sv
// behavioural pair of power supplies facing the sequencer
// assumes the bench clock; fault_kick trips both supplies
`timescale 1ns/10ps
module pes_supply_model (
    // clock
    input wire logic sys_clk,
    // control from the sequencer
    input wire logic supply_enable_n,
    input wire logic supply_shutdown,
    // fault injection
    input wire logic fault_kick,
    // status back
    output logic [1:0] supply_present,
    output logic [1:0] supply_power_good
);
    logic tripped = 1'b0;
    logic [1:0] run_cnt = 2'h0;
    assign supply_present = 2'h3;
    // trip stays latched until the sequencer releases enable (supply_enable_n high)
    always @(posedge sys_clk) begin
        if (fault_kick) tripped <= 1'b1;
        else if (supply_enable_n) tripped <= 1'b0;
        if (supply_enable_n || supply_shutdown || tripped) run_cnt <= 2'h0;
        else if (run_cnt != 2'h3) run_cnt <= run_cnt + 2'h1;
    end
    // good only once outputs have settled and nothing has tripped
    assign supply_power_good = (run_cnt == 2'h3 && !tripped) ? 2'h3 : 2'h0;
endmodule

// ### dv/power_env_sequencer_test.sv
// self-checking bench for the power and environment sequencer
// assumes pes_top, pes_supply_model and the bound checker are compiled
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
    $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module power_env_sequencer_test;
    import pes_pkg::*;
    localparam int TK = 20;
    logic sys_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, temp_value = 8'h19;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic pready, pslverr, perr, supply_enable_n, supply_shutdown, fault_kick = 1'b0;
    logic aux_power_ok = 1'b0, front_switch_on = 1'b0, remote_dc_enable_n = 1'b0;
    logic [1:0] supply_present, supply_power_good, supply_overcurrent = 2'h0;
    logic [1:0] cpu_fan_ok = 2'h3, sys_fan_ok = 2'h3;
    logic cpu1_present = 1'b1, fan_kit_ok = 1'b1, maint_alert_n, panel_we;
    logic [3:0] sw = 4'h8, panel_pos;
    logic [7:0] panel_char;
    logic remote_control_enable, modem_port_enable, remote_use_defaults;
    int bad_count = 0, tests_run = 0, since_alert = 0;

    // ----
    // design, supplies and clock
    // ----
    pes_top #(.TICK_CYCLES(TK)) uut (.sys_clk(sys_clk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .aux_power_ok(aux_power_ok),
        .front_switch_on(front_switch_on), .remote_dc_enable_n(remote_dc_enable_n),
        .supply_present(supply_present), .supply_power_good(supply_power_good),
        .supply_overcurrent(supply_overcurrent), .supply_enable_n(supply_enable_n),
        .supply_shutdown(supply_shutdown), .cpu_fan_ok(cpu_fan_ok),
        .cpu1_present(cpu1_present), .sys_fan_ok(sys_fan_ok), .fan_kit_ok(fan_kit_ok),
        .temp_value(temp_value), .remote_allow_switch(sw[3]), .modem_off_switch(sw[2]),
        .remote_powerdown_disable_switch(sw[1]), .restore_defaults_switch(sw[0]),
        .remote_control_enable(remote_control_enable), .modem_port_enable(modem_port_enable),
        .remote_use_defaults(remote_use_defaults), .maint_alert_n(maint_alert_n),
        .panel_we(panel_we), .panel_pos(panel_pos), .panel_char(panel_char));
    pes_supply_model sup (.sys_clk(sys_clk), .supply_enable_n(supply_enable_n),
        .supply_shutdown(supply_shutdown), .fault_kick(fault_kick),
        .supply_present(supply_present), .supply_power_good(supply_power_good));
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    // length of the current alert, to time the grace period
    always @(posedge sys_clk) since_alert <= maint_alert_n ? 0 : since_alert + 1;

    // ----
    // tasks
    // ----
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge sys_clk);
        `CHK(pready, 1'b1)
        rdat = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rdat, e)
    endtask
    function automatic logic pick(input int s);
        return (s == 0) ? supply_enable_n : (s == 1) ? maint_alert_n : supply_shutdown;
    endfunction
    // bounded wait on enable (0), alert (1) or shutdown (2)
    task automatic wait_pin(input int s, input logic v, input int lim);
        for (int n = 0; n < lim && pick(s) !== v; n++) @(posedge sys_clk);
        `CHK(pick(s), v)
    endtask
    task automatic cycle_front();
        front_switch_on <= 1'b0;
        repeat (8) @(posedge sys_clk);
        apb(1'b1, OFS_ALERT, 32'hF);
        front_switch_on <= 1'b1;
        wait_pin(0, 1'b0, 20);
    endtask
    task wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge sys_clk);
        bad_count++;
        wrap_up();
    end

    // ----
    // tests
    // ----
    initial begin
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        rd_chk(OFS_THRESH, {24'h0, THRESH_RST});
        rd_chk(OFS_ALERT, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        `CHK(perr, 1'b1)
        apb(1'b1, OFS_MEM_ADDR, 32'h5);
        apb(1'b1, OFS_MEM_DATA, 32'hA5C31E0F);
        apb(1'b1, OFS_MEM_ADDR, 32'h6);
        apb(1'b1, OFS_MEM_DATA, 32'h12345678);
        apb(1'b1, OFS_MEM_ADDR, 32'h5);
        rd_chk(OFS_MEM_DATA, 32'hA5C31E0F);
        apb(1'b1, OFS_PANEL, 32'h341);
        @(posedge sys_clk);
        `CHK({panel_pos, panel_char}, 12'h341)
        $display("test registers done");
        aux_power_ok <= 1'b1;
        front_switch_on <= 1'b1;
        wait_pin(0, 1'b0, 20);
        repeat (3 * TK) @(posedge sys_clk);
        rd_chk(OFS_STATE, 32'h00080001);
        rd_chk(OFS_LIVE, 32'h7FF);
        $display("test power on done");
        sys_fan_ok <= 2'b10;
        wait_pin(1, 1'b0, 3 * TK);
        rd_chk(OFS_ALERT, 32'h2);
        cpu1_present <= 1'b0;
        rd_chk(OFS_STATUS, 32'h6FF);
        rd_chk(OFS_LIVE, 32'h6BF);
        wait_pin(2, 1'b1, 32 * TK);
        `CHK(since_alert >= 30 * TK - 4 && since_alert <= 30 * TK + 4, 1'b1)
        `CHK(supply_enable_n, 1'b1)
        sys_fan_ok <= 2'b11;
        cpu1_present <= 1'b1;
        front_switch_on <= 1'b0;
        repeat (8) @(posedge sys_clk);
        `CHK(supply_shutdown, 1'b0)
        rd_chk(OFS_STATE, 32'h00080000);
        cycle_front();
        rd_chk(OFS_ALERT, 32'h0);
        $display("test fan grace done");
        apb(1'b1, OFS_THRESH, 32'h40);
        temp_value <= 8'h40;
        repeat (3 * TK) @(posedge sys_clk);
        rd_chk(OFS_ALERT, 32'h0);
        temp_value <= 8'h41;
        cpu_fan_ok <= 2'b01;
        wait_pin(1, 1'b0, 3 * TK);
        rd_chk(OFS_ALERT, 32'h5);
        temp_value <= 8'h19;
        cpu_fan_ok <= 2'h3;
        cycle_front();
        $display("test overtemp done");
        remote_dc_enable_n <= 1'b1;
        wait_pin(0, 1'b1, 10);
        sw[1] <= 1'b1;
        wait_pin(0, 1'b0, 20);
        supply_overcurrent <= 2'b01;
        repeat (6) @(posedge sys_clk);
        supply_overcurrent <= 2'b00;
        rd_chk(OFS_ALERT, 32'h8);
        cycle_front();
        fault_kick <= 1'b1;
        @(posedge sys_clk);
        fault_kick <= 1'b0;
        repeat (3 * TK) @(posedge sys_clk);
        apb(1'b0, OFS_STATE, 32'h0);
        `CHK(rdat[2:0], 3'h2)
        cycle_front();
        $display("test remote and supply faults done");
        for (int i = 0; i < 16; i++) begin
            sw <= i[3:0];
            repeat (5) @(posedge sys_clk);
            `CHK({remote_control_enable, modem_port_enable, remote_use_defaults},
                {i[3], ~i[2], i[0]})
        end
        $display("test switches done");
        wrap_up();
    end
endmodule
